// ### hdl/csd_pkg.sv
// Shared constants for the cycle-steal inbound engine and its control unit partner
package csd_pkg;
   // I/O addresses decoded by the adapter
   localparam logic [7:0]  ADR_START     = 8'h62;
   localparam logic [7:0]  ADR_COUNT     = 8'h6c;
   localparam logic [7:0]  ADR_XADDR     = 8'h6e;
   localparam logic [7:0]  ADR_ADDR      = 8'h6f;
   localparam logic [7:0]  ADR_IRQ_SRC   = 8'h77;
   // Bit positions in a 16-bit word {byte0, byte1}; bit 0.0 is the word's msb
   localparam int          B_0_1         = 14;
   localparam int          B_0_4         = 11;
   localparam int          B_0_5         = 10;
   localparam int          B_0_6         = 9;
   localparam int          B_0_7         = 8;
   localparam int          B_1_0         = 7;
   localparam int          B_1_4         = 3;
   localparam int          B_1_6         = 1;
   localparam int          B_1_7         = 0;
   // Ending characters watched on channel bus-out (EBCDIC)
   localparam logic [7:0]  CHR_ETB       = 8'h26;
   localparam logic [7:0]  CHR_ETX       = 8'h03;
   // A loaded count of zero means the largest transfer
   localparam logic [8:0]  CNT_MAX       = 9'h100;
   localparam logic [7:0]  CNT_ZERO      = 8'h00;
   localparam logic [1:0]  XADR_ONES     = 2'h3;
   localparam logic [1:0]  XADR_STEP     = 2'h1;
   localparam logic [15:0] ADR_STEP_ONE  = 16'h0001;
   localparam logic [15:0] ADR_STEP_TWO  = 16'h0002;
   localparam logic [15:0] ADR_ZERO      = 16'h0000;
endpackage

// ### hdl/csd_if.sv
// Link between the channel adapter and the central control unit
`timescale 1ns/1ps
interface csd_if;
   logic        io_wr;
   logic        io_rd;
   logic [7:0]  io_addr;
   logic [15:0] io_wdata;
   logic [15:0] io_rdata;
   logic        io_rvalid;
   logic        steal_req;
   logic        go_steal;
   logic [17:0] adbus;
   logic        adbus_vld;
   logic        store_b0;
   logic        store_b1;
   logic [15:0] inbus;
   logic [15:0] outbus;
   logic        outbus_vld;
   logic        l3_irq;

   modport adapter (
      input  io_wr, io_rd, io_addr, io_wdata, go_steal, outbus, outbus_vld,
      output io_rdata, io_rvalid, steal_req, adbus, adbus_vld, store_b0, store_b1, inbus, l3_irq
   );
   modport control_unit (
      output io_wr, io_rd, io_addr, io_wdata, go_steal, outbus, outbus_vld,
      input  io_rdata, io_rvalid, steal_req, adbus, adbus_vld, store_b0, store_b1, inbus, l3_irq
   );
endinterface

// ### hdl/csd_adapter.sv
// Channel adapter end: inbound cycle-steal engine with channel tag handshake
// Notes on behaviour
// - only buffer locations 0 and 1 are used
// - odd start stores byte 1 only
// - ending after byte 0 stores byte 0 only
// - service in held off during steal
// - service and steal alternate until end, then interrupt
// - count write loads count, sets but never clears steal mode
// - address write loads low bytes, extended byte to zero
// - extended byte written only when its bits nonzero
// - software order: count, address, extended, start
// - odd address sets odd latch, buffer address 1
// - each byte steps counter, full pair requests steal
// - fetch resets buffer address, loads input register
// - on grant drive 18-bit address and strobes
// - control unit increments, adapter reloads low address
// - zero returned address steps extended byte
// - both strobes for pairs, byte 1 after odd
// - end character in monitored mode stops, interrupts
// - count reached stops service, interrupts
// - count write decodes mode, monitors, count
// - start write decodes inbound, resets, proceed
// - interrupt source read reports three bits
// - count covers 1 through 256 bytes
`timescale 1ns/1ps
module csd_adapter
   import csd_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   csd_if.adapter          bus,
   input  wire logic       svc_out_i,
   input  wire logic [7:0] bus_out_i,
   input  wire logic       emulation_subchannel_mode_i,
   input  wire logic       init_sel_evt_i,
   input  wire logic       adapter_sel_i,
   output logic            svc_in_o,
   output logic            l3_req_o
);

   typedef enum logic [2:0] {ST_IDLE, ST_SVC, ST_FETCH, ST_REQ, ST_SAMPLE} csd_state_e;

   csd_state_e  state_q;
   logic [8:0]  sy1_q, sy2_q, sy3_q;
   logic        so_lvl_q;
   logic        so_rise;
   logic [7:0]  count_q;
   logic        steal_mode_q, syn_mon_q, ebc_mon_q;
   logic [15:0] steal_address_reg_q;
   logic [1:0]  xadr_q;
   logic        xfix_q;
   logic        odd_q, bufadr_q, b0ctl_q, b1ctl_q;
   logic [7:0]  buf_q [2];
   logic [8:0]  cnt_q;
   logic [8:0]  cnt_d;
   logic [8:0]  limit;
   logic        inbound_q, proceed_q, init_svc_q, stop_q;
   logic        l3_q, isel_q;
   logic        wr_count, wr_addr, wr_xaddr, wr_start, rd_src;
   logic        end_chr, last_byte;

   assign wr_count = bus.io_wr && bus.io_addr == ADR_COUNT;
   assign wr_addr  = bus.io_wr && bus.io_addr == ADR_ADDR;
   assign wr_xaddr = bus.io_wr && bus.io_addr == ADR_XADDR;
   assign wr_start = bus.io_wr && bus.io_addr == ADR_START;
   assign rd_src   = bus.io_rd && bus.io_addr == ADR_IRQ_SRC;

   // Service out and bus-out come from the channel; three stages, service out accepted when the last two agree
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sy1_q    <= '0;
         sy2_q    <= '0;
         sy3_q    <= '0;
         so_lvl_q <= 1'b0;
      end else begin
         sy1_q <= {svc_out_i, bus_out_i};
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         if (sy2_q[8] == sy3_q[8]) begin
            so_lvl_q <= sy3_q[8];
         end
      end
   end
   assign so_rise = sy2_q[8] && sy3_q[8] && !so_lvl_q;

   assign limit     = (count_q == CNT_ZERO) ? CNT_MAX : {1'b0, count_q};
   assign cnt_d     = cnt_q + 9'h001;
   assign end_chr   = emulation_subchannel_mode_i && ebc_mon_q && (sy3_q[7:0] == CHR_ETB || sy3_q[7:0] == CHR_ETX);
   assign last_byte = (cnt_d == limit) || end_chr;

   // Programmed loads and the steal/service sequence share state, so they live together
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_q       <= ST_IDLE;
         count_q       <= '0;
         steal_mode_q  <= 1'b0;
         syn_mon_q     <= 1'b0;
         ebc_mon_q     <= 1'b0;
         steal_address_reg_q <= '0;
         xadr_q        <= '0;
         xfix_q        <= 1'b0;
         odd_q         <= 1'b0;
         bufadr_q      <= 1'b0;
         b0ctl_q       <= 1'b0;
         b1ctl_q       <= 1'b0;
         buf_q[0]      <= '0;
         buf_q[1]      <= '0;
         cnt_q         <= '0;
         inbound_q     <= 1'b0;
         proceed_q     <= 1'b0;
         init_svc_q    <= 1'b0;
         stop_q        <= 1'b0;
         svc_in_o      <= 1'b0;
         bus.steal_req <= 1'b0;
         bus.adbus     <= '0;
         bus.adbus_vld <= 1'b0;
         bus.store_b0  <= 1'b0;
         bus.store_b1  <= 1'b0;
         bus.inbus     <= '0;
      end else begin
         bus.adbus_vld <= 1'b0;
         if (wr_count) begin
            count_q      <= bus.io_wdata[B_1_0:0];
            steal_mode_q <= steal_mode_q | bus.io_wdata[B_0_1];
            syn_mon_q    <= syn_mon_q | bus.io_wdata[B_0_4];
            ebc_mon_q    <= ebc_mon_q | bus.io_wdata[B_0_7];
            bufadr_q     <= 1'b0;
         end
         if (wr_addr) begin
            steal_address_reg_q <= bus.io_wdata;
            xadr_q   <= XADR_ONES;
            xfix_q   <= 1'b1;
            odd_q    <= bus.io_wdata[B_1_7];
            if (bus.io_wdata[B_1_7]) begin
               bufadr_q <= 1'b1;
               b0ctl_q  <= 1'b1;
            end
         end else if (xfix_q) begin
            // Forced ones roll over to zero, saving the extended-byte write
            xadr_q <= xadr_q + XADR_STEP;
            xfix_q <= 1'b0;
         end else if (wr_xaddr) begin
            xadr_q <= bus.io_wdata[B_1_6:B_1_7];
         end
         if (wr_start) begin
            inbound_q  <= bus.io_wdata[B_0_1];
            proceed_q  <= 1'b1;
            init_svc_q <= bus.io_wdata[B_0_1] && steal_mode_q;
            cnt_q      <= '0;
            stop_q     <= 1'b0;
         end
         unique case (state_q)
            ST_IDLE: begin
               if (init_svc_q && proceed_q && inbound_q) begin
                  state_q <= ST_SVC;
               end
            end
            ST_SVC: begin
               if (!init_svc_q) begin
                  svc_in_o <= 1'b0;
                  state_q  <= ST_IDLE;
               end else if (!svc_in_o && !so_lvl_q) begin
                  svc_in_o <= 1'b1;
               end else if (svc_in_o && so_rise) begin
                  svc_in_o          <= 1'b0;
                  buf_q[bufadr_q]   <= sy3_q[7:0];
                  bufadr_q          <= !bufadr_q;
                  cnt_q             <= cnt_d;
                  if (bufadr_q) begin
                     b1ctl_q <= 1'b1;
                  end
                  if (last_byte) begin
                     stop_q     <= 1'b1;
                     init_svc_q <= 1'b0;
                  end
                  if (bufadr_q || last_byte) begin
                     state_q <= ST_FETCH;
                  end
               end
            end
            ST_FETCH: begin
               bufadr_q      <= 1'b0;
               bus.inbus     <= {buf_q[0], buf_q[1]};
               bus.steal_req <= 1'b1;
               state_q       <= ST_REQ;
            end
            ST_REQ: begin
               if (bus.go_steal) begin
                  bus.steal_req <= 1'b0;
                  bus.adbus     <= {xadr_q, steal_address_reg_q};
                  bus.adbus_vld <= 1'b1;
                  bus.store_b0  <= !b0ctl_q;
                  bus.store_b1  <= b1ctl_q;
                  state_q       <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               if (bus.outbus_vld) begin
                  steal_address_reg_q <= bus.outbus;
                  if (bus.outbus == ADR_ZERO) begin
                     xadr_q <= xadr_q + XADR_STEP;
                  end
                  odd_q   <= 1'b0;
                  b0ctl_q <= 1'b0;
                  b1ctl_q <= 1'b0;
                  // Service resumes only now that the steal is complete
                  state_q <= stop_q ? ST_IDLE : ST_SVC;
                  if (stop_q) begin
                     proceed_q <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // Interrupt latches; a new event wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         l3_q   <= 1'b0;
         isel_q <= 1'b0;
      end else begin
         if (state_q == ST_SAMPLE && bus.outbus_vld && stop_q) begin
            l3_q <= 1'b1;
         end else if (wr_start && bus.io_wdata[B_0_6]) begin
            l3_q <= 1'b0;
         end
         if (init_sel_evt_i) begin
            isel_q <= 1'b1;
         end else if (wr_start && bus.io_wdata[B_0_5]) begin
            isel_q <= 1'b0;
         end
      end
   end

   // Read-back; unmapped read addresses return zero
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bus.io_rdata  <= '0;
         bus.io_rvalid <= 1'b0;
         bus.l3_irq    <= 1'b0;
         l3_req_o      <= 1'b0;
      end else begin
         bus.io_rvalid <= bus.io_rd;
         bus.io_rdata  <= '0;
         if (rd_src) begin
            bus.io_rdata[B_1_0] <= l3_q;
            bus.io_rdata[B_1_4] <= isel_q;
            bus.io_rdata[B_1_6] <= adapter_sel_i;
         end
         bus.l3_irq <= l3_q || isel_q;
         l3_req_o   <= l3_q;
      end
   end

endmodule

// ### hdl/csd_ccu.sv
// Control unit end: I/O instruction port and cycle-steal storage write with address update
`timescale 1ns/1ps
module csd_control_unit
   import csd_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   csd_if.control_unit      bus,
   input  wire logic        sw_wr_i,
   input  wire logic        sw_rd_i,
   input  wire logic [7:0]  sw_addr_i,
   input  wire logic [15:0] sw_wdata_i,
   output logic [15:0]      sw_rdata_o,
   output logic             sw_rvalid_o,
   output logic             irq_l3_o,
   output logic             mem_we_o,
   output logic [17:0]      mem_addr_o,
   output logic [1:0]       mem_be_o,
   output logic [15:0]      mem_wdata_o
);

   logic        granted_q;
   logic [15:0] step;

   // Software issues count, address, extended byte, then start, in that order
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bus.io_wr    <= 1'b0;
         bus.io_rd    <= 1'b0;
         bus.io_addr  <= '0;
         bus.io_wdata <= '0;
         sw_rdata_o   <= '0;
         sw_rvalid_o  <= 1'b0;
         irq_l3_o     <= 1'b0;
      end else begin
         bus.io_wr    <= sw_wr_i;
         bus.io_rd    <= sw_rd_i;
         bus.io_addr  <= sw_addr_i;
         bus.io_wdata <= sw_wdata_i;
         sw_rvalid_o  <= bus.io_rvalid;
         sw_rdata_o   <= bus.io_rvalid ? bus.io_rdata : '0;
         irq_l3_o     <= bus.l3_irq;
      end
   end

   assign step = (bus.store_b0 && bus.store_b1) ? ADR_STEP_TWO : ADR_STEP_ONE;

   // Grant one steal cycle per request; the store and the address update follow
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         granted_q      <= 1'b0;
         bus.go_steal   <= 1'b0;
         bus.outbus     <= '0;
         bus.outbus_vld <= 1'b0;
         mem_we_o       <= 1'b0;
         mem_addr_o     <= '0;
         mem_be_o       <= '0;
         mem_wdata_o    <= '0;
      end else begin
         bus.go_steal   <= 1'b0;
         bus.outbus_vld <= 1'b0;
         mem_we_o       <= 1'b0;
         if (bus.steal_req && !granted_q) begin
            bus.go_steal <= 1'b1;
            granted_q    <= 1'b1;
         end
         if (bus.adbus_vld) begin
            // Unstrobed byte is rewritten unchanged by leaving its lane disabled
            mem_we_o       <= 1'b1;
            mem_addr_o     <= bus.adbus;
            mem_be_o       <= {bus.store_b0, bus.store_b1};
            mem_wdata_o    <= bus.inbus;
            bus.outbus     <= bus.adbus[15:0] + step;
            bus.outbus_vld <= 1'b1;
            granted_q      <= 1'b0;
         end
      end
   end

endmodule

// ### tb/csd_asserts.sv
// Checker for the adapter to control unit link of the cycle-steal engine
`timescale 1ns/1ps
module csd_asserts
   import csd_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        io_wr,
   input wire logic        io_rd,
   input wire logic [7:0]  io_addr,
   input wire logic [15:0] io_rdata,
   input wire logic        io_rvalid,
   input wire logic        steal_req,
   input wire logic        go_steal,
   input wire logic [17:0] adbus,
   input wire logic        adbus_vld,
   input wire logic        store_b0,
   input wire logic        store_b1,
   input wire logic [15:0] outbus,
   input wire logic        outbus_vld
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // Predicted next steal address; a fresh address load makes it stale
   logic        trk_q;
   logic [17:0] nxt_q;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         trk_q <= 1'b0;
         nxt_q <= 18'h00000;
      end else if (io_wr && (io_addr == ADR_ADDR || io_addr == ADR_XADDR)) begin
         trk_q <= 1'b0;
      end else if (outbus_vld) begin
         trk_q <= 1'b1;
         nxt_q <= {adbus[17:16] + {1'b0, outbus == ADR_ZERO}, outbus};
      end
   end

   property p_grant_to_addr;
      go_steal |=> adbus_vld;
   endproperty
   a_grant_to_addr: assert property (p_grant_to_addr) else $error("address not driven after grant");
   property p_addr_from_grant;
      adbus_vld |-> $past(go_steal);
   endproperty
   a_addr_from_grant: assert property (p_addr_from_grant) else $error("address without grant");
   property p_strobes;
      adbus_vld |-> (store_b0 || store_b1);
   endproperty
   a_strobes: assert property (p_strobes) else $error("no store strobe with address");
   property p_req_hold;
      steal_req && !go_steal |=> steal_req;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("steal bid dropped before grant");
   property p_req_drop;
      go_steal |=> !steal_req;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("steal bid kept after grant");
   property p_update;
      adbus_vld |=> outbus_vld && outbus == adbus[15:0] + ((store_b0 && store_b1) ? ADR_STEP_TWO : ADR_STEP_ONE);
   endproperty
   a_update: assert property (p_update) else $error("updated address wrong");
   property p_reload;
      adbus_vld && trk_q |-> adbus == nxt_q;
   endproperty
   a_reload: assert property (p_reload) else $error("steal address not reloaded");
   property p_rd_answer;
      io_rd |=> io_rvalid ##1 !io_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer timing wrong");
   property p_rd_idle;
      !io_rvalid |-> io_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
endmodule

// ### tb/cycle_steal_inbound_dma_tb_top.sv
// Self-checking testbench joining both ends of the cycle-steal engine
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module cycle_steal_inbound_dma_tb_top;
   import csd_pkg::*;
   logic        clk_sys_i = 0;
   logic        rst_i = 1;
   logic        sw_wr_i = 0;
   logic        sw_rd_i = 0;
   logic        svc_out_i = 0;
   logic        emulation_subchannel_mode_i = 0;
   logic        init_sel_evt_i = 0;
   logic        adapter_sel_i = 0;
   logic [7:0]  sw_addr_i = 0;
   logic [7:0]  bus_out_i = 0;
   logic [15:0] sw_wdata_i = 0;
   logic [15:0] sw_rdata_o;
   logic [15:0] mem_wdata_o;
   logic        sw_rvalid_o, irq_l3_o, mem_we_o, svc_in_o, l3_req_o;
   logic [17:0] mem_addr_o;
   logic [1:0]  mem_be_o;
   logic [1:0]  be_e;
   logic [7:0]  exp_b;
   logic [17:0] exp_ptr = 0;
   logic [7:0]  eq[$];
   int          fail_count = 0;
   int          tests_run = 0;
   integer      seed = 32'hbeefe44e;

   always #10 clk_sys_i = ~clk_sys_i;

   csd_if u_csd_if ();
   csd_adapter u_csd_adapter (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(u_csd_if.adapter), .svc_out_i(svc_out_i),
      .bus_out_i(bus_out_i), .emulation_subchannel_mode_i(emulation_subchannel_mode_i),
      .init_sel_evt_i(init_sel_evt_i), .adapter_sel_i(adapter_sel_i), .svc_in_o(svc_in_o), .l3_req_o(l3_req_o));
   csd_control_unit u_csd_control_unit (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(u_csd_if.control_unit),
      .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_rdata_o(sw_rdata_o),
      .sw_rvalid_o(sw_rvalid_o), .irq_l3_o(irq_l3_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_be_o(mem_be_o), .mem_wdata_o(mem_wdata_o));
   csd_asserts u_csd_asserts (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .io_wr(u_csd_if.io_wr), .io_rd(u_csd_if.io_rd),
      .io_addr(u_csd_if.io_addr), .io_rdata(u_csd_if.io_rdata), .io_rvalid(u_csd_if.io_rvalid),
      .steal_req(u_csd_if.steal_req), .go_steal(u_csd_if.go_steal), .adbus(u_csd_if.adbus),
      .adbus_vld(u_csd_if.adbus_vld), .store_b0(u_csd_if.store_b0), .store_b1(u_csd_if.store_b1),
      .outbus(u_csd_if.outbus), .outbus_vld(u_csd_if.outbus_vld));

   function automatic logic [1:0] exp_be(input logic [17:0] p, input int rem);
      if (p[0])
         return 2'b01;
      if (rem == 1)
         return 2'b10;
      return 2'b11;
   endfunction

   task automatic close_out();
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Storage side: every write must match the next bytes of the stream
   always @(posedge clk_sys_i) begin
      if (mem_we_o === 1'b1) begin
         be_e = exp_be(exp_ptr, eq.size());
         `CHK(mem_be_o, be_e)
         `CHK(mem_addr_o, exp_ptr)
         if (be_e[1]) begin
            exp_b = eq.pop_front();
            `CHK(mem_wdata_o[15:8], exp_b)
         end
         if (be_e[0]) begin
            exp_b = eq.pop_front();
            `CHK(mem_wdata_o[7:0], exp_b)
         end
         exp_ptr = exp_ptr + ((be_e == 2'b11) ? 18'h2 : 18'h1);
      end
      if (u_csd_if.steal_req === 1'b1)
         `CHK(svc_in_o, 1'b0)
   end

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      #1;
      sw_wr_i = 1;
      sw_addr_i = a;
      sw_wdata_i = d;
      @(posedge clk_sys_i);
      #1;
      sw_wr_i = 0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys_i);
      #1;
      sw_rd_i = 1;
      sw_addr_i = a;
      @(posedge clk_sys_i);
      #1;
      sw_rd_i = 0;
      // Answer stands one cycle, two edges after the request is taken
      repeat (2) @(posedge clk_sys_i);
      #1;
      `CHK(sw_rvalid_o, 1'b1)
      d = sw_rdata_o;
   endtask

   task automatic wait_sig(input int w, input logic v);
      int i = 0;
      while (((w == 0) ? svc_in_o : irq_l3_o) !== v && i < 600) begin
         @(posedge clk_sys_i);
         #1;
         i++;
      end
      if (i >= 600) begin
         fail_count++;
         close_out();
      end
   endtask

   // Channel side: bus-out goes inverse once released, so stale data cannot pass
   task automatic chan(input logic [7:0] b[$]);
      foreach (b[i]) begin
         wait_sig(0, 1'b1);
         bus_out_i = b[i];
         @(posedge clk_sys_i);
         #1;
         svc_out_i = 1;
         wait_sig(0, 1'b0);
         svc_out_i = 0;
         bus_out_i = ~b[i];
      end
   endtask

   task automatic xfer(input logic [17:0] a, input logic [7:0] cnt, input int n, input logic [7:0] endc);
      logic [7:0]  b[$];
      logic [15:0] r;
      for (int i = 0; i < n; i++) begin
         b.push_back(8'($random(seed)));
         // Ending characters stay in the stream when monitoring is off, so they must be ignored
         if (emulation_subchannel_mode_i && (b[i] == CHR_ETX || b[i] == CHR_ETB))
            b[i] = 8'h55;
      end
      if (endc != 8'h00)
         b[n-1] = endc;
      exp_ptr = a;
      eq = b;
      wr(ADR_COUNT, {8'h49, cnt});
      wr(ADR_ADDR, a[15:0]);
      if (a[17:16] != 2'h0) begin
         repeat (2) @(posedge clk_sys_i);
         wr(ADR_XADDR, {14'h0000, a[17:16]});
      end
      wr(ADR_START, 16'h4600);
      chan(b);
      wait_sig(1, 1'b1);
      `CHK(l3_req_o, 1'b1)
      `CHK(eq.size() == 0, 1'b1)
      repeat (8) @(posedge clk_sys_i);
      `CHK(svc_in_o, 1'b0)
      rd(ADR_IRQ_SRC, r);
      `CHK(r, 16'h0080)
   endtask

   initial begin
      repeat (40000) @(posedge clk_sys_i);
      fail_count++;
      close_out();
   end

   initial begin
      logic [15:0] r;
      int          n;
      repeat (6) @(posedge clk_sys_i);
      #1;
      rst_i = 0;
      adapter_sel_i = 1;
      init_sel_evt_i = 1;
      @(posedge clk_sys_i);
      #1;
      init_sel_evt_i = 0;
      rd(ADR_IRQ_SRC, r);
      `CHK(r, 16'h000a)
      rd(8'h50, r);
      `CHK(r, 16'h0000)
      adapter_sel_i = 0;
      // Carry out of the low bytes must step the extended byte
      xfer({2'h1, 16'hfffe}, 8'h04, 4, 8'h00);
      xfer({2'h0, 16'h0101}, 8'h02, 2, 8'h00);
      for (int k = 0; k < 4; k++) begin
         n = int'($unsigned($random(seed)) % 12) + 1;
         xfer(18'($random(seed)), 8'(n), n, 8'h00);
      end
      xfer(18'h00200, 8'h00, 256, 8'h00);
      emulation_subchannel_mode_i = 1;
      xfer(18'h00301, 8'h40, 6, CHR_ETX);
      xfer(18'h00400, 8'h40, 5, CHR_ETB);
      close_out();
   end
endmodule
